// ### hdl/single_wire_backlight_ctrl.sv
module single_wire_backlight_ctrl
  import backlight_pkg::*;
#(
  parameter int unsigned SOFT_CYCLES  = SOFT_START_CYC,
  parameter int unsigned CHECK_CYCLES = SHORT_CHECK_CYC,
  parameter int unsigned PRE_CYCLES   = PRECHARGE_CYC
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         data_pin,
  input  wire logic         pump_short_in,
  input  wire logic         headroom_low_in,
  input  wire logic         headroom_high_in,
  output logic [10:0]       backlight_control,
  output led_ctrl_t         led_ctrl,
  output pump_ctrl_t        pump_ctrl,
  output logic              transfer_done
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int unsigned RAMP_STEP = SOFT_CYCLES / RAMP_STEPS;

  if (RAMP_STEP < 1 || SOFT_CYCLES >= (1 << PUMP_TMR_W) ||
      CHECK_CYCLES < 1 || CHECK_CYCLES >= (1 << PUMP_TMR_W) ||
      PRE_CYCLES < 1 || PRE_CYCLES >= (1 << PUMP_TMR_W)) begin : g_chk
    $error("single_wire_backlight_ctrl: pump timing out of range");
  end

  localparam logic [PUMP_TMR_W-1:0] STEP_LAST  =
    PUMP_TMR_W'(RAMP_STEP - 1);
  localparam logic [PUMP_TMR_W-1:0] CHECK_LAST =
    PUMP_TMR_W'(CHECK_CYCLES - 1);
  localparam logic [PUMP_TMR_W-1:0] PRE_LAST   =
    PUMP_TMR_W'(PRE_CYCLES - 1);
  localparam logic [3:0] CTRL_BITS = 4'(CTRL_WIDTH);
  localparam logic [3:0] RAMP_TOP  = 4'(RAMP_STEPS - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0]             ctrl;
    logic [10:0]             shadow;
    logic [3:0]              bit_cnt;
    logic                    long_run;
    pump_state_t             ps;
    pump_ratio_t             ratio;
    logic [PUMP_TMR_W-1:0]   tmr;
    logic [3:0]              ramp;
    logic [2:0]              asy0;
    logic [2:0]              asy1;
    logic [2:0]              asy2;
    logic [2:0]              ana;
    led_ctrl_t               led;
    pump_ctrl_t              pump;
    logic                    done;
  } ctrl_state_t;

  ctrl_state_t  st_reg;
  ctrl_state_t  st_next;
  pulse_event_t evt;
  logic [3:0]   chan_on;
  logic [11:0]  commit_mask;

  // ----------------------------------------------------------------
  // Pulse timing on the data pin
  // ----------------------------------------------------------------
  pulse_timer #(
    .SHORT_MIN (SHORT_MIN_CYC),
    .SHORT_MAX (SHORT_MAX_CYC),
    .LONG_MIN  (LONG_MIN_CYC)
  ) u_pulse_timer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .data_pin (data_pin),
    .evt      (evt)
  );

  // ----------------------------------------------------------------
  // Channel selection
  // ----------------------------------------------------------------
  // Code n lights channels 0..n, so at least one string is lit whenever the pump is in soft start or run
  for (genvar ch = 0; ch < LED_CHANNELS; ch++) begin : g_chan
    assign chan_on[ch] =
      (2'(ch) <= st_next.ctrl[LED_SEL_LSB +: 2]);
  end

  // Bits not sent in this transfer keep their old value
  assign commit_mask = (12'h001 << st_reg.bit_cnt) - 12'h001;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;

    // Analog flags: three stages, a change counts when 1 and 2 agree
    st_next.asy0 = {headroom_high_in, headroom_low_in, pump_short_in};
    st_next.asy1 = st_reg.asy0;
    st_next.asy2 = st_reg.asy1;
    st_next.ana  = (st_reg.asy1 & st_reg.asy2) |
                   (st_reg.ana & (st_reg.asy1 ^ st_reg.asy2));

    // --- Serial decode ---
    case (evt.kind)
      EV_BIT: begin
        st_next.long_run = 1'b0;
        // Bits past the eleventh are dropped
        if (st_reg.bit_cnt < CTRL_BITS) begin
          st_next.shadow[st_reg.bit_cnt] = evt.value;
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end
      end
      EV_LONG: begin
        if (st_reg.long_run) begin
          // Second long pulse in a row closes the transfer
          st_next.long_run = 1'b0;
          st_next.bit_cnt  = 4'h0;
          if (st_reg.bit_cnt != 4'h0) begin
            st_next.ctrl = (st_reg.shadow & commit_mask[10:0]) |
                           (st_reg.ctrl & ~commit_mask[10:0]);
            st_next.done = 1'b1;
          end
        end else begin
          st_next.long_run = 1'b1;
        end
      end
      EV_DROP: begin
        st_next.long_run = 1'b0;
      end
      default: begin
        st_next.long_run = st_reg.long_run;
      end
    endcase

    // --- Pump sequencing ---
    case (st_reg.ps)
      PS_OFF: begin
        st_next.ramp  = 4'h0;
        st_next.ratio = RATIO_1X;
        if (st_reg.ctrl[BIT_ENABLE]) begin
          st_next.ps  = PS_SHORT_CHECK;
          st_next.tmr = '0;
        end
      end
      PS_SHORT_CHECK: begin
        // A short sensed restarts the window; no conversion until clear
        if (st_reg.ana[0]) begin
          st_next.tmr = '0;
        end else if (st_reg.tmr == CHECK_LAST) begin
          st_next.ps  = PS_PRECHARGE;
          st_next.tmr = '0;
        end else begin
          st_next.tmr = st_reg.tmr + 1'b1;
        end
      end
      PS_PRECHARGE: begin
        if (st_reg.tmr == PRE_LAST) begin
          st_next.ps   = PS_SOFT_START;
          st_next.tmr  = '0;
          st_next.ramp = 4'h0;
        end else begin
          st_next.tmr = st_reg.tmr + 1'b1;
        end
      end
      PS_SOFT_START: begin
        if (st_reg.tmr == STEP_LAST) begin
          st_next.tmr = '0;
          if (st_reg.ramp == RAMP_TOP) begin
            st_next.ps = PS_RUN;
          end else begin
            st_next.ramp = st_reg.ramp + 4'h1;
          end
        end else begin
          st_next.tmr = st_reg.tmr + 1'b1;
        end
      end
      PS_RUN: begin
        // Step up takes priority: losing LED current is worse
        if (st_reg.ana[1] && st_reg.ratio != RATIO_2X) begin
          st_next.ratio = (st_reg.ratio == RATIO_1X) ?
                          RATIO_1P5X : RATIO_2X;
          st_next.ps    = PS_SOFT_START;
          st_next.tmr   = '0;
          st_next.ramp  = 4'h0;
        end else if (st_reg.ana[2] && st_reg.ratio != RATIO_1X) begin
          st_next.ratio = (st_reg.ratio == RATIO_2X) ?
                          RATIO_1P5X : RATIO_1X;
          st_next.ps    = PS_SOFT_START;
          st_next.tmr   = '0;
          st_next.ramp  = 4'h0;
        end
      end
      default: begin
        st_next.ps = PS_OFF;
      end
    endcase

    // Clearing enable wins over every sequencing step; a ratio step taken in run still leaves its new ratio for one cycle
    if (!st_reg.ctrl[BIT_ENABLE]) begin
      st_next.ps   = PS_OFF;
      st_next.tmr  = '0;
      st_next.ramp = 4'h0;
    end

    // --- Registered outputs ---
    st_next.led.enable             = st_next.ctrl[BIT_ENABLE];
    st_next.led.low_current_select =
      st_next.ctrl[BIT_LOW_CURRENT];
    st_next.led.output_mode_field  = st_next.ctrl[MODE_LSB +: 2];
    st_next.led.brightness         = st_next.ctrl[BRIGHT_LSB +: 5];
    // Numerator over 32 of full scale; analog divides by ten in low mode
    st_next.led.current_level      =
      {1'b0, st_next.ctrl[BRIGHT_LSB +: 5]} + 6'h01;
    if (st_next.ps == PS_SOFT_START || st_next.ps == PS_RUN) begin
      st_next.led.led_enable = chan_on;
    end else begin
      st_next.led.led_enable = 4'h0;
    end

    st_next.pump.ratio          = st_next.ratio;
    st_next.pump.ramp           = st_next.ramp;
    st_next.pump.discharge_en   = (st_next.ps == PS_OFF);
    st_next.pump.short_check_en = (st_next.ps == PS_SHORT_CHECK);
    st_next.pump.precharge_en   = (st_next.ps == PS_PRECHARGE);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Only the power-on reset clears the control word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg                   <= '0;
      st_reg.ctrl              <= CTRL_RESET;
      st_reg.ps                <= PS_OFF;
      st_reg.ratio             <= RATIO_1X;
      st_reg.pump.ratio        <= RATIO_1X;
      st_reg.pump.discharge_en <= 1'b1;
      st_reg.led.current_level <= 6'h01;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign backlight_control = st_reg.ctrl;
  assign led_ctrl          = st_reg.led;
  assign pump_ctrl         = st_reg.pump;
  assign transfer_done     = st_reg.done;

endmodule // single_wire_backlight_ctrl

// ### hdl/backlight_pkg.sv
package backlight_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned SHORT_MIN_NS   = 1500;
  localparam int unsigned SHORT_MAX_NS   = 3500;
  localparam int unsigned LONG_MIN_NS    = 8000;
  localparam int unsigned SOFT_START_NS  = 200000;
  localparam int unsigned SHORT_CHECK_NS = 2000;
  localparam int unsigned PRECHARGE_NS   = 4000;

  // Least times round up, longest times round down
  localparam int unsigned SHORT_MIN_CYC =
    (SHORT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_MAX_CYC = SHORT_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned LONG_MIN_CYC =
    (LONG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SOFT_START_CYC =
    (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_CHECK_CYC =
    (SHORT_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRECHARGE_CYC =
    (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned TIMER_W    = 12;
  localparam int unsigned PUMP_TMR_W = 16;
  localparam int unsigned RAMP_STEPS = 16;

  // ----------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_WIDTH      = 11;
  localparam logic [10:0] CTRL_RESET      = 11'h000;
  localparam int unsigned BIT_ENABLE      = 0;
  localparam int unsigned BIT_LOW_CURRENT = 1;
  localparam int unsigned LED_SEL_LSB     = 2;
  localparam int unsigned MODE_LSB        = 4;
  localparam int unsigned BRIGHT_LSB      = 6;
  localparam int unsigned LED_CHANNELS    = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {EV_NONE, EV_BIT, EV_LONG, EV_DROP}
    pulse_kind_t;

  typedef struct packed {
    pulse_kind_t kind;
    logic        value;
  } pulse_event_t;

  typedef enum logic [1:0] {RATIO_1X, RATIO_1P5X, RATIO_2X} pump_ratio_t;

  typedef enum logic [2:0] {
    PS_OFF, PS_SHORT_CHECK, PS_PRECHARGE, PS_SOFT_START, PS_RUN
  } pump_state_t;

  typedef struct packed {
    logic       enable;
    logic       low_current_select;
    logic [3:0] led_enable;
    logic [1:0] output_mode_field;
    logic [4:0] brightness;
    logic [5:0] current_level;
  } led_ctrl_t;

  typedef struct packed {
    pump_ratio_t ratio;
    logic [3:0]  ramp;
    logic        discharge_en;
    logic        short_check_en;
    logic        precharge_en;
  } pump_ctrl_t;

endpackage

// ### hdl/pulse_timer.sv
module pulse_timer
  import backlight_pkg::*;
#(
  parameter int unsigned SHORT_MIN = SHORT_MIN_CYC,
  parameter int unsigned SHORT_MAX = SHORT_MAX_CYC,
  parameter int unsigned LONG_MIN  = LONG_MIN_CYC
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         data_pin,
  output pulse_event_t      evt
);

  if (!(SHORT_MIN >= 1 && SHORT_MIN <= SHORT_MAX &&
        SHORT_MAX < LONG_MIN && LONG_MIN < (1 << TIMER_W) - 1)) begin : g_chk
    $error("pulse_timer: thresholds out of order or too wide");
  end

  localparam logic [TIMER_W-1:0] SMIN_W = TIMER_W'(SHORT_MIN);
  localparam logic [TIMER_W-1:0] SMAX_W = TIMER_W'(SHORT_MAX);
  localparam logic [TIMER_W-1:0] LMIN_W = TIMER_W'(LONG_MIN);

  typedef struct packed {
    logic [2:0]         sync;
    logic               level;
    logic [TIMER_W-1:0] count;
    logic               long_seen;
    pulse_event_t       evt;
  } timer_state_t;

  timer_state_t cur_reg;
  timer_state_t cur_next;

  // ----------------------------------------------------------------
  // Width measurement
  // ----------------------------------------------------------------
  always_comb begin
    cur_next      = cur_reg;
    cur_next.sync = {cur_reg.sync[1:0], data_pin};
    cur_next.evt  = '{kind: EV_NONE, value: 1'b0};
    // Stage 0 feeds stage 1 only; a level counts once 1 and 2 agree
    if (cur_reg.sync[2] == cur_reg.sync[1] &&
        cur_reg.sync[2] != cur_reg.level) begin
      cur_next.level     = cur_reg.sync[2];
      cur_next.count     = {{(TIMER_W-1){1'b0}}, 1'b1};
      cur_next.long_seen = 1'b0;
      if (cur_reg.long_seen) begin
        cur_next.evt.kind = EV_NONE; // Already reported
      end else if (cur_reg.count >= SMIN_W &&
                   cur_reg.count <= SMAX_W) begin
        cur_next.evt.kind  = EV_BIT;
        cur_next.evt.value = cur_reg.level;
      end else begin
        cur_next.evt.kind = EV_DROP;
      end
    end else begin
      if (cur_reg.count != {TIMER_W{1'b1}}) begin
        cur_next.count = cur_reg.count + 1'b1;
      end
      // Long is flagged while it lasts, once per level, so an idle line alone gives one long and a frame ends on the second
      if (!cur_reg.long_seen && cur_reg.count == LMIN_W - 1'b1) begin
        cur_next.long_seen = 1'b1;
        cur_next.evt.kind  = EV_LONG;
        cur_next.evt.value = cur_reg.level;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign evt = cur_reg.evt;

endmodule // pulse_timer

// ### sim/backlight_properties.sv
module backlight_properties
  import backlight_pkg::*;
#(
  parameter int unsigned SOFT_CYCLES  = SOFT_START_CYC,
  parameter int unsigned CHECK_CYCLES = SHORT_CHECK_CYC,
  parameter int unsigned PRE_CYCLES   = PRECHARGE_CYC
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        data_pin,
  input wire logic        pump_short_in,
  input wire logic        headroom_low_in,
  input wire logic        headroom_high_in,
  input wire logic [10:0] backlight_control,
  input wire led_ctrl_t   led_ctrl,
  input wire pump_ctrl_t  pump_ctrl,
  input wire logic        transfer_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Quiet time on the raw pin, saturating
  // ----------------------------------------------------------------
  logic [11:0] quiet_reg;
  logic        pin_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      quiet_reg <= 12'h000;
      pin_reg   <= 1'h0;
    end else begin
      pin_reg <= data_pin;
      if (data_pin != pin_reg) begin
        quiet_reg <= 12'h000;
      end else if (quiet_reg != 12'hfff) begin
        quiet_reg <= quiet_reg + 12'h001;
      end
    end
  end

  property p_hold;
    $changed(backlight_control) |-> transfer_done;
  endproperty
  a_hold: assert property (p_hold)
    else $error("control word changed without a commit");
  property p_done_once;
    transfer_done |=> !transfer_done;
  endproperty
  a_done_once: assert property (p_done_once)
    else $error("commit pulse longer than one cycle");
  // A commit is only legal once a full long level has stood on the pin
  property p_done_long;
    transfer_done |-> quiet_reg >= LONG_MIN_CYC - 1;
  endproperty
  a_done_long: assert property (p_done_long)
    else $error("commit without a long closing level");
  property p_fields;
    led_ctrl.enable == backlight_control[0] &&
    led_ctrl.low_current_select == backlight_control[1] &&
    led_ctrl.output_mode_field == backlight_control[5:4] &&
    led_ctrl.brightness == backlight_control[10:6];
  endproperty
  a_fields: assert property (p_fields)
    else $error("control fields do not follow the word");
  property p_level;
    led_ctrl.current_level == {1'h0, led_ctrl.brightness} + 6'h01;
  endproperty
  a_level: assert property (p_level)
    else $error("current level is not code plus one");
  property p_shutdown;
    !led_ctrl.enable [*3] |-> pump_ctrl.discharge_en &&
      led_ctrl.led_enable == 4'h0 && !pump_ctrl.short_check_en &&
      !pump_ctrl.precharge_en;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown state not entered");
  property p_start;
    $rose(led_ctrl.enable) |-> ##[0:2] pump_ctrl.short_check_en;
  endproperty
  a_start: assert property (p_start)
    else $error("short check did not start");
  property p_pre;
    $fell(pump_ctrl.short_check_en) && led_ctrl.enable
      |-> pump_ctrl.precharge_en;
  endproperty
  a_pre: assert property (p_pre)
    else $error("precharge did not follow short check");
  property p_dark;
    pump_ctrl.short_check_en || pump_ctrl.precharge_en
      |-> led_ctrl.led_enable == 4'h0;
  endproperty
  a_dark: assert property (p_dark)
    else $error("channels lit before pump ready");
  property p_ramp;
    $changed(pump_ctrl.ramp) && pump_ctrl.ramp != 4'h0
      |-> pump_ctrl.ramp == $past(pump_ctrl.ramp) + 4'h1;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp skipped a step");
  property p_ratio;
    $changed(pump_ctrl.ratio) && led_ctrl.enable
      |-> ##[0:1] pump_ctrl.ramp == 4'h0;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("ratio change without a new ramp");

  c_done: cover property (transfer_done);
  c_pre: cover property ($rose(pump_ctrl.precharge_en));
  c_double: cover property (pump_ctrl.ratio == RATIO_2X);
  c_full: cover property (pump_ctrl.ramp == 4'hf);
endmodule // backlight_properties

// ### sim/host_model.sv
module host_model (
  input  wire logic clk_sys,
  output logic      data_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin has a pull-down, so idle and reset level is low
  localparam int unsigned SHORT_W = 500;
  localparam int unsigned LONG_W  = 2200;
  logic lvl = 1'h0;
  initial data_pin = 1'h0;

  task automatic hold(input logic v, input int unsigned n);
    data_pin <= v;
    lvl = v;
    repeat (n) @(posedge clk_sys);
  endtask

  // Short pulses sit at 500 cycles, inside the 375 to 875 window, so oscillator drift cannot push them out
  task automatic send(input logic [10:0] bits, input int unsigned n);
    for (int i = 0; i < n; i++) begin
      if (lvl == bits[i]) hold(~bits[i], LONG_W);
      hold(bits[i], SHORT_W);
    end
    hold(~lvl, LONG_W);
    hold(~lvl, LONG_W);
    if (lvl) hold(1'h0, LONG_W);
  endtask
endmodule // host_model

// ### sim/tb.sv
module tb;
  import backlight_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [10:0] bits;
    int unsigned n;
    logic [10:0] exp;
    logic [3:0]  leds;
  } row_t;

  logic        clk_sys;
  logic        rst_n;
  logic        data_pin;
  logic        pump_short_in;
  logic        headroom_low_in;
  logic        headroom_high_in;
  logic [10:0] backlight_control;
  led_ctrl_t   led_ctrl;
  pump_ctrl_t  pump_ctrl;
  logic        transfer_done;
  logic        saw_pre = 1'h0;
  int          n_errors = 0;
  int          checks = 0;
  int          n_done = 0;
  // Mode field written as zero in the first row and not sent in the second
  row_t rows [2] = '{'{11'h545, 11, 11'h545, 4'h3},
                     '{11'h002, 2, 11'h546, 4'h0}};

  host_model host (.clk_sys(clk_sys), .data_pin(data_pin));

  // Short pump timings keep the run small
  single_wire_backlight_ctrl #(
    .SOFT_CYCLES(64), .CHECK_CYCLES(4), .PRE_CYCLES(4)
  ) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .data_pin(data_pin),
    .pump_short_in(pump_short_in), .headroom_low_in(headroom_low_in),
    .headroom_high_in(headroom_high_in),
    .backlight_control(backlight_control), .led_ctrl(led_ctrl),
    .pump_ctrl(pump_ctrl), .transfer_done(transfer_done)
  );

  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (transfer_done === 1'h1) n_done <= n_done + 1;
    if (pump_ctrl.precharge_en === 1'h1) saw_pre <= 1'h1;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic expect_word(input logic [10:0] exp, input logic [3:0] leds,
                             input int base);
    #1;
    chk("commits", n_done, base + 1);
    chk("control", backlight_control, exp);
    chk("enable", led_ctrl.enable, exp[0]);
    chk("low current", led_ctrl.low_current_select, exp[1]);
    chk("brightness", led_ctrl.brightness, exp[10:6]);
    chk("level", led_ctrl.current_level, exp[10:6] + 6'h01);
    chk("leds", led_ctrl.led_enable, leds);
    chk("discharge", pump_ctrl.discharge_en, !exp[0]);
    @(posedge clk_sys);
  endtask

  initial begin
    int base;
    rst_n = 1'h0;
    pump_short_in = 1'h0;
    headroom_low_in = 1'h0;
    headroom_high_in = 1'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      base = n_done;
      host.send(rows[i].bits, rows[i].n);
      expect_word(rows[i].exp, rows[i].leds, base);
    end
    // ----------------------------------------------------------------
    // Awkward cases
    // ----------------------------------------------------------------
    pump_short_in <= 1'h1;
    base = n_done;
    host.send(11'h001, 1);
    #1;
    chk("check held", pump_ctrl.short_check_en, 1'h1);
    chk("dark in check", led_ctrl.led_enable, 4'h0);
    @(posedge clk_sys);
    pump_short_in <= 1'h0;
    for (int k = 0; k < 2000 && pump_ctrl.ramp !== 4'hf; k++)
      @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    chk("precharge seen", saw_pre, 1'h1);
    expect_word(11'h547, 4'h3, base);
    headroom_low_in <= 1'h1;
    for (int k = 0; k < 2000 && pump_ctrl.ratio !== RATIO_2X; k++)
      @(posedge clk_sys);
    #1;
    chk("ratio up", pump_ctrl.ratio, RATIO_2X);
    @(posedge clk_sys);
    headroom_low_in <= 1'h0;
    headroom_high_in <= 1'h1;
    for (int k = 0; k < 2000 && pump_ctrl.ratio !== RATIO_1X; k++)
      @(posedge clk_sys);
    #1;
    chk("ratio down", pump_ctrl.ratio, RATIO_1X);
    @(posedge clk_sys);
    headroom_high_in <= 1'h0;
    // Mid-width pulse between two longs must not close the transfer
    base = n_done;
    host.hold(1'h1, 500);
    host.hold(1'h0, 500);
    host.hold(1'h1, 2200);
    host.hold(1'h0, 1200);
    host.hold(1'h1, 2200);
    #1;
    chk("no early commit", n_done, base);
    @(posedge clk_sys);
    host.hold(1'h0, 2200);
    expect_word(11'h545, 4'h3, base);
    rst_n <= 1'h0;
    @(posedge clk_sys);
    #1;
    chk("reset word", backlight_control, 11'h000);
    chk("reset level", led_ctrl.current_level, 6'h01);
    chk("reset discharge", pump_ctrl.discharge_en, 1'h1);
    @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    // Two longs with no bit between them must not commit
    base = n_done;
    host.hold(1'h0, 2200);
    host.hold(1'h1, 2200);
    host.hold(1'h0, 2200);
    #1;
    chk("empty commit", n_done, base);
    chk("empty word", backlight_control, 11'h000);
    @(posedge clk_sys);
    conclude();
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end
endmodule // tb

bind single_wire_backlight_ctrl backlight_properties #(
  .SOFT_CYCLES(SOFT_CYCLES), .CHECK_CYCLES(CHECK_CYCLES),
  .PRE_CYCLES(PRE_CYCLES)
) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .data_pin(data_pin),
  .pump_short_in(pump_short_in), .headroom_low_in(headroom_low_in),
  .headroom_high_in(headroom_high_in),
  .backlight_control(backlight_control), .led_ctrl(led_ctrl),
  .pump_ctrl(pump_ctrl), .transfer_done(transfer_done)
);
